// ### core/ppdc_regs.sv
// Purpose: Pad pull-resistor and drive-strength configuration bank
// Assumes: APB master on clk_sys; paddr is the local byte offset
// Notes:   Decoded pad controls are registered, one cycle after the field
//
// Operation
// [RULE1] A write changes stored bit n only where written bit n+16 is one.
// [RULE2] A zero mask bit keeps its stored field bit unchanged.
// [RULE3] Pull fields: two bits per pin, none, pull-up, pull-down, keeper.
// [RULE4] Drive fields: two bits per pin, 2, 4, 8 or 12 mA.
// [RULE5] Reset pull fields port1 B, C, D: 56A5, 9A65, AAAA.
// [RULE6] Reset pull fields port2 A, B, C: 9556, 959A, 5565.
// [RULE7] Reset port2 D and port3 A 55A5; port3 B 5AAA, C 6555.
// [RULE8] Reset drive fields 8011, 005A, AAAA for port0 A, D, port1 A.
// [RULE9] Pull registers from 0x110 upward; drive registers from 0x200.
// [RULE10] Mask half is write-only, resets to zero, never stored.
// [RULE11] Port1 bank A pull register at 0x110, reset A555.
// [RULE12] Pin n uses field bits 2n+1 down to 2n.
// [RULE13] Reads return zero upper half and the stored field below.
`timescale 1ns/10ps
`default_nettype none
module ppdc_regs
  import ppdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire ppdc_apb_req_type apb_req,
  output ppdc_apb_rsp_type apb_rsp,
  output ppdc_pad_type pad_cfg,
  output ppdc_bank_type pull_p1a,
  output logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_up_en,
  output logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_down_en,
  output logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] keeper_en,
  output logic [PPDC_NUM_DRIVE-1:0][PPDC_PINS-1:0][PPDC_LEGS-1:0] drive_legs
);

  // Field storage, one word per register
  logic [PPDC_FIELD_W-1:0] field [PPDC_NUM_REGS];
  logic [PPDC_FIELD_W-1:0] field_p1a;

  // Decode results
  logic [PPDC_NUM_REGS-1:0] hit_vec;
  logic hit_p1a;
  logic addr_hit;
  logic [PPDC_FIELD_W-1:0] rd_field;
  logic wr_commit;

  // Decoded pad controls
  logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_up_nxt;
  logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_down_nxt;
  logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] keeper_nxt;
  logic [PPDC_NUM_DRIVE-1:0][PPDC_PINS-1:0][PPDC_LEGS-1:0] legs_nxt;
  logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_up_r;
  logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_down_r;
  logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] keeper_r;
  logic [PPDC_NUM_DRIVE-1:0][PPDC_PINS-1:0][PPDC_LEGS-1:0] legs_r;

  // Bank views for decoding; entry 0 of the pull view is port1 bank A
  ppdc_bank_type [PPDC_NUM_PULL:0] pull_view;
  ppdc_bank_type [PPDC_NUM_DRIVE-1:0] drive_view;

  // Address decode, full 12-bit compare so misaligned offsets miss
  always_comb begin
    hit_vec = '0;
    for (int i = 0; i < PPDC_NUM_REGS; i++) begin
      // [RULE9] fixed word offsets
      hit_vec[i] = (apb_req.paddr == PPDC_OFFSETS[i]);
    end
  end

  // [RULE11] separate offset for port1 bank A
  assign hit_p1a = (apb_req.paddr == PPDC_OFF_PULL_P1A);
  assign addr_hit = hit_p1a | (|hit_vec);

  // Read mux; an AND-OR tree keeps the path shallow across 14 words
  always_comb begin
    rd_field = hit_p1a ? field_p1a : PPDC_ZERO_HALF;
    for (int i = 0; i < PPDC_NUM_REGS; i++) begin
      if (hit_vec[i]) begin
        // [RULE13] stored field returned
        rd_field = rd_field | field[i];
      end
    end
  end

  // Bus handshake and response flops
  ppdc_apb_slave u_apb (
    .clk_sys(clk_sys),
    .srst(srst),
    .apb_req(apb_req),
    .addr_hit(addr_hit),
    .rd_field(rd_field),
    .apb_rsp_r(apb_rsp),
    .wr_commit(wr_commit)
  );

  // [RULE11] port1 bank A field with its own reset
  ppdc_mask_reg #(
    .RESET_VAL(PPDC_RST_PULL_P1A)
  ) u_pull_p1a (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_en(wr_commit & hit_p1a),
    .wdata(apb_req.pwdata),
    .field_r(field_p1a)
  );

  // One masked field per remaining register; the mask itself is never held
  for (genvar g = 0; g < PPDC_NUM_REGS; g++) begin : g_field
    // [RULE5] [RULE6] [RULE7] [RULE8] per-register reset
    // [RULE10] mask not stored
    ppdc_mask_reg #(
      .RESET_VAL(PPDC_RESETS[g])
    ) u_field (
      .clk_sys(clk_sys),
      .srst(srst),
      .wr_en(wr_commit & hit_vec[g]),
      .wdata(apb_req.pwdata),
      .field_r(field[g])
    );
  end

  // Fields straight into the bank views, no extra delay
  always_comb begin
    pull_view[0] = field_p1a;
    for (int b = 0; b < PPDC_NUM_PULL; b++) begin
      pull_view[b+1] = field[b];
    end
    for (int d = 0; d < PPDC_NUM_DRIVE; d++) begin
      drive_view[d] = field[PPDC_NUM_PULL+d];
    end
  end

  assign pull_p1a = pull_view[0];

  // Raw field outputs in bank order, port1 bank B first
  always_comb begin
    pad_cfg = '0;
    for (int b = 0; b < PPDC_NUM_PULL; b++) begin
      pad_cfg.pull[b] = pull_view[b+1];
    end
    pad_cfg.drive = drive_view;
  end

  // Pull decode per pin; keeper is exclusive of the resistors
  always_comb begin
    pull_up_nxt = '0;
    pull_down_nxt = '0;
    keeper_nxt = '0;
    for (int b = 0; b <= PPDC_NUM_PULL; b++) begin
      for (int p = 0; p < PPDC_PINS; p++) begin
        // [RULE12] pin pair select
        // [RULE3] pull code decode
        case (ppdc_pull_type'(pull_view[b][p]))
          PPDC_PULL_NONE: begin
            pull_up_nxt[b][p] = 1'b0;
          end
          PPDC_PULL_UP: begin
            pull_up_nxt[b][p] = 1'b1;
          end
          PPDC_PULL_DOWN: begin
            pull_down_nxt[b][p] = 1'b1;
          end
          PPDC_PULL_KEEP: begin
            keeper_nxt[b][p] = 1'b1;
          end
          default: begin
            pull_up_nxt[b][p] = 1'b0;
          end
        endcase
      end
    end
  end

  // Drive decode: base leg gives 2 mA, extra legs add up to 12 mA
  always_comb begin
    legs_nxt = '0;
    for (int d = 0; d < PPDC_NUM_DRIVE; d++) begin
      for (int p = 0; p < PPDC_PINS; p++) begin
        // [RULE12] pin pair select
        // [RULE4] drive code decode
        case (ppdc_drive_type'(drive_view[d][p]))
          PPDC_DRV_2MA: begin
            legs_nxt[d][p] = PPDC_LEGS_NONE;
          end
          PPDC_DRV_4MA: begin
            legs_nxt[d][p] = PPDC_LEGS_ONE;
          end
          PPDC_DRV_8MA: begin
            legs_nxt[d][p] = PPDC_LEGS_TWO;
          end
          PPDC_DRV_12MA: begin
            legs_nxt[d][p] = PPDC_LEGS_ALL;
          end
          default: begin
            legs_nxt[d][p] = PPDC_LEGS_NONE;
          end
        endcase
      end
    end
  end

  // Registered pad enables; reset drives them all off until fields settle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pull_up_r <= '0;
      pull_down_r <= '0;
      keeper_r <= '0;
      legs_r <= '0;
    end else begin
      pull_up_r <= pull_up_nxt;
      pull_down_r <= pull_down_nxt;
      keeper_r <= keeper_nxt;
      legs_r <= legs_nxt;
    end
  end

  assign pull_up_en = pull_up_r;
  assign pull_down_en = pull_down_r;
  assign keeper_en = keeper_r;
  assign drive_legs = legs_r;

endmodule
`default_nettype wire

// ### core/ppdc_pkg.sv
// Purpose: Shared constants and types for the pad pull and drive config bank
// Assumes: APB slave on a 12-bit local byte address, 32-bit data
// Notes:   Each register has a 16-bit field and a write-only mask half
package ppdc_pkg;

  localparam int PPDC_NUM_REGS = 13;
  localparam int PPDC_NUM_PULL = 10;
  localparam int PPDC_NUM_DRIVE = 3;
  localparam int PPDC_PINS = 8;
  localparam int PPDC_FIELD_W = 16;
  localparam int PPDC_DATA_W = 32;
  localparam int PPDC_ADDR_W = 12;
  localparam int PPDC_MASK_LSB = 16;
  localparam int PPDC_LEGS = 3;

  // Byte offsets of the bank
  localparam logic [11:0] PPDC_OFF_PULL_P1A = 12'h110;
  localparam logic [11:0] PPDC_OFF_PULL_P1B = 12'h114;
  localparam logic [11:0] PPDC_OFF_PULL_P1C = 12'h118;
  localparam logic [11:0] PPDC_OFF_PULL_P1D = 12'h11C;
  localparam logic [11:0] PPDC_OFF_PULL_P2A = 12'h120;
  localparam logic [11:0] PPDC_OFF_PULL_P2B = 12'h124;
  localparam logic [11:0] PPDC_OFF_PULL_P2C = 12'h128;
  localparam logic [11:0] PPDC_OFF_PULL_P2D = 12'h12C;
  localparam logic [11:0] PPDC_OFF_PULL_P3A = 12'h130;
  localparam logic [11:0] PPDC_OFF_PULL_P3B = 12'h134;
  localparam logic [11:0] PPDC_OFF_PULL_P3C = 12'h138;
  localparam logic [11:0] PPDC_OFF_DRV_P0A = 12'h200;
  localparam logic [11:0] PPDC_OFF_DRV_P0D = 12'h20C;
  localparam logic [11:0] PPDC_OFF_DRV_P1A = 12'h210;

  // Field reset values
  localparam logic [15:0] PPDC_RST_PULL_P1A = 16'hA555;
  localparam logic [15:0] PPDC_RST_PULL_P1B = 16'h56A5;
  localparam logic [15:0] PPDC_RST_PULL_P1C = 16'h9A65;
  localparam logic [15:0] PPDC_RST_PULL_P1D = 16'hAAAA;
  localparam logic [15:0] PPDC_RST_PULL_P2A = 16'h9556;
  localparam logic [15:0] PPDC_RST_PULL_P2B = 16'h959A;
  localparam logic [15:0] PPDC_RST_PULL_P2C = 16'h5565;
  localparam logic [15:0] PPDC_RST_PULL_P2D = 16'h55A5;
  localparam logic [15:0] PPDC_RST_PULL_P3A = 16'h55A5;
  localparam logic [15:0] PPDC_RST_PULL_P3B = 16'h5AAA;
  localparam logic [15:0] PPDC_RST_PULL_P3C = 16'h6555;
  localparam logic [15:0] PPDC_RST_DRV_P0A = 16'h8011;
  localparam logic [15:0] PPDC_RST_DRV_P0D = 16'h005A;
  localparam logic [15:0] PPDC_RST_DRV_P1A = 16'hAAAA;

  // Index 0..9 pull banks, 10..12 drive banks; P1A sits outside the run
  localparam logic [11:0] PPDC_OFFSETS [PPDC_NUM_REGS] = '{
    PPDC_OFF_PULL_P1B, PPDC_OFF_PULL_P1C, PPDC_OFF_PULL_P1D,
    PPDC_OFF_PULL_P2A, PPDC_OFF_PULL_P2B, PPDC_OFF_PULL_P2C,
    PPDC_OFF_PULL_P2D, PPDC_OFF_PULL_P3A, PPDC_OFF_PULL_P3B,
    PPDC_OFF_PULL_P3C, PPDC_OFF_DRV_P0A, PPDC_OFF_DRV_P0D,
    PPDC_OFF_DRV_P1A};
  localparam logic [15:0] PPDC_RESETS [PPDC_NUM_REGS] = '{
    PPDC_RST_PULL_P1B, PPDC_RST_PULL_P1C, PPDC_RST_PULL_P1D,
    PPDC_RST_PULL_P2A, PPDC_RST_PULL_P2B, PPDC_RST_PULL_P2C,
    PPDC_RST_PULL_P2D, PPDC_RST_PULL_P3A, PPDC_RST_PULL_P3B,
    PPDC_RST_PULL_P3C, PPDC_RST_DRV_P0A, PPDC_RST_DRV_P0D,
    PPDC_RST_DRV_P1A};

  localparam logic [15:0] PPDC_ZERO_HALF = 16'h0000;
  localparam logic [2:0] PPDC_LEGS_NONE = 3'h0;
  localparam logic [2:0] PPDC_LEGS_ONE = 3'h1;
  localparam logic [2:0] PPDC_LEGS_TWO = 3'h3;
  localparam logic [2:0] PPDC_LEGS_ALL = 3'h7;

  typedef enum logic [1:0] {
    PPDC_PULL_NONE = 2'h0,
    PPDC_PULL_UP = 2'h1,
    PPDC_PULL_DOWN = 2'h2,
    PPDC_PULL_KEEP = 2'h3
  } ppdc_pull_type;

  typedef enum logic [1:0] {
    PPDC_DRV_2MA = 2'h0,
    PPDC_DRV_4MA = 2'h1,
    PPDC_DRV_8MA = 2'h2,
    PPDC_DRV_12MA = 2'h3
  } ppdc_drive_type;

  typedef enum logic [1:0] {
    PPDC_APB_IDLE = 2'b01,
    PPDC_APB_ACK = 2'b10
  } ppdc_apb_state_type;

  typedef logic [PPDC_PINS-1:0][1:0] ppdc_bank_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [PPDC_ADDR_W-1:0] paddr;
    logic [PPDC_DATA_W-1:0] pwdata;
  } ppdc_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [PPDC_DATA_W-1:0] prdata;
  } ppdc_apb_rsp_type;

  typedef struct packed {
    ppdc_bank_type [PPDC_NUM_PULL-1:0] pull;
    ppdc_bank_type [PPDC_NUM_DRIVE-1:0] drive;
  } ppdc_pad_type;

endpackage

// ### core/ppdc_mask_reg.sv
// Purpose: One 16-bit config field with a per-bit write mask
// Assumes: Mask lives in the upper half of the written word
// Notes:   The mask is never stored
`timescale 1ns/10ps
`default_nettype none
module ppdc_mask_reg
  import ppdc_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [PPDC_DATA_W-1:0] wdata,
  output logic [PPDC_FIELD_W-1:0] field_r
);

  logic [PPDC_FIELD_W-1:0] field_nxt;
  logic [PPDC_FIELD_W-1:0] mask;

  // Merge masked data into the held field
  always_comb begin
    mask = wdata[PPDC_DATA_W-1:PPDC_MASK_LSB];
    field_nxt = field_r;
    if (wr_en) begin
      // [RULE1] [RULE2] masked bit update
      field_nxt = (field_r & ~mask) | (wdata[PPDC_FIELD_W-1:0] & mask);
    end
  end

  // Register only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      field_r <= RESET_VAL;
    end else begin
      field_r <= field_nxt;
    end
  end

endmodule
`default_nettype wire

// ### core/ppdc_apb_slave.sv
// Purpose: APB handshake for the config bank, one wait state per access
// Assumes: Master follows APB setup and access phases
// Notes:   Writes commit on the completing edge only
`timescale 1ns/10ps
`default_nettype none
module ppdc_apb_slave
  import ppdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire ppdc_apb_req_type apb_req,
  input wire logic addr_hit,
  input wire logic [PPDC_FIELD_W-1:0] rd_field,
  output ppdc_apb_rsp_type apb_rsp_r,
  output logic wr_commit
);

  ppdc_apb_state_type state_r;
  ppdc_apb_state_type state_nxt;
  ppdc_apb_rsp_type rsp_nxt;
  logic access;

  assign access = apb_req.psel & apb_req.penable;

  // Write lands only when the master sees pready high
  assign wr_commit = (state_r == PPDC_APB_ACK) & access & apb_req.pwrite
    & ~apb_rsp_r.pslverr;

  // Next state and response
  always_comb begin
    state_nxt = state_r;
    rsp_nxt = '0;
    case (state_r)
      PPDC_APB_IDLE: begin
        if (access) begin
          state_nxt = PPDC_APB_ACK;
          rsp_nxt.pready = 1'b1;
          rsp_nxt.pslverr = ~addr_hit;
          if (addr_hit && !apb_req.pwrite) begin
            // [RULE13] mask half reads zero
            rsp_nxt.prdata = {PPDC_ZERO_HALF, rd_field};
          end
        end
      end
      PPDC_APB_ACK: begin
        state_nxt = PPDC_APB_IDLE;
      end
      default: begin
        state_nxt = PPDC_APB_IDLE;
      end
    endcase
  end

  // Register only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= PPDC_APB_IDLE;
      apb_rsp_r <= '0;
    end else begin
      state_r <= state_nxt;
      apb_rsp_r <= rsp_nxt;
    end
  end

endmodule
`default_nettype wire

// ### testbench/ppdc_regs_checker.sv
// Purpose: Port checks on the pad config bank
// Assumes: One clock, synchronous active-high reset
// Notes: Decoded enables lag the fields by one cycle
`timescale 1ns/10ps
`default_nettype none
module ppdc_regs_checker
  import ppdc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire ppdc_apb_req_type apb_req,
  input wire ppdc_apb_rsp_type apb_rsp,
  input wire ppdc_pad_type pad_cfg,
  input wire ppdc_bank_type pull_p1a,
  input wire logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_up_en,
  input wire logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] pull_down_en,
  input wire logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] keeper_en,
  input wire logic [PPDC_NUM_DRIVE-1:0][PPDC_PINS-1:0][PPDC_LEGS-1:0] drive_legs
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic wr_done;
  logic [7:0] up_x, dn_x, kp_x;
  logic [7:0][2:0] leg_x;
  // Decode worked out here, not copied from the design
  always_comb begin
    wr_done = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;
    for (int p = 0; p < 8; p++) begin
      up_x[p] = (pull_p1a[p] == 2'h1);
      dn_x[p] = (pull_p1a[p] == 2'h2);
      kp_x[p] = (pull_p1a[p] == 2'h3);
      leg_x[p] = {&pad_cfg.drive[0][p], pad_cfg.drive[0][p][1], |pad_cfg.drive[0][p]};
    end
  end
  property p_ack_lat;
    apb_req.psel && !apb_req.penable |-> ##2 apb_rsp.pready;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("answer late");
  property p_ack_pulse;
    apb_rsp.pready |=> !apb_rsp.pready;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ready too long");
  property p_rd_upper;
    apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("mask half read");
  property p_err_zero;
    apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error data");
  // Reset edge excluded: the fields load their reset values there instead of holding
  property p_hold;
    !srst && !wr_done |=> $stable(pad_cfg) && $stable(pull_p1a);
  endproperty
  a_hold: assert property (p_hold) else $error("field moved");
  property p_mask_p1c;
    wr_done && apb_req.paddr == 12'h118 |=> pad_cfg.pull[1] ==
      (($past(pad_cfg.pull[1]) & ~$past(apb_req.pwdata[31:16]))
      | ($past(apb_req.pwdata[15:0]) & $past(apb_req.pwdata[31:16])));
  endproperty
  a_mask_p1c: assert property (p_mask_p1c) else $error("masked write");
  // Start only from a cycle out of reset, so the forced-low enables are skipped
  property p_pull_dec;
    !srst |=> keeper_en[0] == $past(kp_x) && pull_up_en[0] == $past(up_x)
      && pull_down_en[0] == $past(dn_x);
  endproperty
  a_pull_dec: assert property (p_pull_dec) else $error("pull decode");
  property p_leg_dec;
    !srst |=> drive_legs[0] == $past(leg_x);
  endproperty
  a_leg_dec: assert property (p_leg_dec) else $error("drive decode");
  property p_rst_vals;
    $fell(srst) |-> pull_p1a == 16'hA555 && pad_cfg.pull[0] == 16'h56A5
      && pad_cfg.drive[0] == 16'h8011;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset value");
  c_wr: cover property (wr_done);
  c_err: cover property (apb_rsp.pslverr);
  c_keep: cover property (keeper_en[0] != 8'h00);
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench for the pad config bank
// Assumes: APB answer comes one wait state after access
// Notes: Expected answers queue up; a monitor pops them
`timescale 1ns/10ps
`default_nettype none
module tb
  import ppdc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  ppdc_apb_req_type req = '0;
  ppdc_apb_rsp_type rsp;
  ppdc_pad_type pad_cfg;
  ppdc_bank_type pull_p1a;
  logic [PPDC_NUM_PULL:0][PPDC_PINS-1:0] up_en, dn_en, kp_en;
  logic [PPDC_NUM_DRIVE-1:0][PPDC_PINS-1:0][PPDC_LEGS-1:0] legs;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [32:0] exp_q [$];
  logic [15:0] mdl [14];
  // Index 0 port1 A, 1..10 pulls, 11..13 drives
  localparam logic [11:0] OFF [14] = '{12'h110, 12'h114, 12'h118, 12'h11C, 12'h120,
    12'h124, 12'h128, 12'h12C, 12'h130, 12'h134, 12'h138, 12'h200, 12'h20C, 12'h210};
  localparam logic [15:0] RST [14] = '{16'hA555, 16'h56A5, 16'h9A65, 16'hAAAA, 16'h9556,
    16'h959A, 16'h5565, 16'h55A5, 16'h55A5, 16'h5AAA, 16'h6555, 16'h8011, 16'h005A, 16'hAAAA};
  localparam logic [11:0] BAD [5] = '{12'h10C, 12'h13C, 12'h119, 12'h204, 12'h214};
  always #2 clk_sys = ~clk_sys;
  ppdc_regs dut_u (.clk_sys(clk_sys), .srst(srst), .apb_req(req), .apb_rsp(rsp),
    .pad_cfg(pad_cfg), .pull_p1a(pull_p1a), .pull_up_en(up_en), .pull_down_en(dn_en),
    .keeper_en(kp_en), .drive_legs(legs));
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic int idx(input logic [11:0] a);
    idx = -1;
    for (int k = 0; k < 14; k++) if (OFF[k] === a) idx = k;
  endfunction
  // Setup, access, hold until pready; unmapped places expect an error
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    i = idx(a);
    exp_q.push_back({i < 0, (w || i < 0) ? 32'h0 : {16'h0000, mdl[i]}});
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // No local limit: only the bench timeout may end this wait
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    req <= '0;
    if (w && i >= 0) mdl[i] = (mdl[i] & ~d[31:16]) | (d[15:0] & d[31:16]);
  endtask
  // Fields and decoded pad controls against the model
  task automatic check_pads();
    logic [7:0] u, dn, k;
    logic [7:0][2:0] lg;
    logic [1:0] c;
    logic [15:0] f;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    for (int i = 0; i < 14; i++) begin
      for (int p = 0; p < 8; p++) begin
        c = mdl[i][2*p +: 2];
        u[p] = (c == 2'h1);
        dn[p] = (c == 2'h2);
        k[p] = (c == 2'h3);
        lg[p] = {&c, c[1], |c};
      end
      f = (i == 0) ? pull_p1a : (i < 11) ? pad_cfg.pull[i-1] : pad_cfg.drive[i-11];
      chk("field", {17'h0, f}, {17'h0, mdl[i]});
      if (i < 11) chk("pull", {9'h0, up_en[i], dn_en[i], kp_en[i]}, {9'h0, u, dn, k});
      else chk("legs", {9'h0, legs[i-11]}, {9'h0, lg});
    end
    // Back onto a rising edge so the next drive, reset too, leaves from it
    @(posedge clk_sys);
  endtask
  task automatic do_reset();
    srst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    mdl = RST;
  endtask
  // Each answer takes the oldest note; a hang ends the run
  always @(posedge clk_sys) begin
    cyc++;
    if (rsp.pready === 1'b1) begin
      chk("apb", {rsp.pslverr, rsp.prdata}, exp_q.size() ? exp_q.pop_front() : '1);
    end
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  initial begin
    int r;
    void'($urandom(32'h258E8C8A));
    do_reset();
    for (int i = 0; i < 14; i++) xfer(OFF[i], 1'b0, 32'h0);
    check_pads();
    for (int i = 0; i < 14; i++) xfer(OFF[i], 1'b1, 32'hFFFF_E4E4);
    check_pads();
    for (int i = 0; i < 14; i++) xfer(OFF[i], 1'b1, 32'h0000_1B1B);
    for (int i = 0; i < 14; i++) xfer(OFF[i], 1'b0, 32'h0);
    for (int i = 0; i < 5; i++) begin
      xfer(BAD[i], 1'b1, 32'hFFFF_FFFF);
      xfer(BAD[i], 1'b0, 32'h0);
    end
    check_pads();
    for (int j = 0; j < 60; j++) begin
      r = $urandom_range(13);
      xfer(OFF[r], 1'b1, $urandom);
      xfer(OFF[r], 1'b0, 32'h0);
    end
    check_pads();
    do_reset();
    for (int i = 0; i < 14; i++) xfer(OFF[i], 1'b0, 32'h0);
    check_pads();
    chk("pending", 33'(exp_q.size()), 33'h0);
    complete_run();
  end
endmodule
bind ppdc_regs ppdc_regs_checker chk_u (.clk_sys(clk_sys), .srst(srst), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .pad_cfg(pad_cfg), .pull_p1a(pull_p1a), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .keeper_en(keeper_en), .drive_legs(drive_legs));
`default_nettype wire
